// >>> otg_vbus_monitor_control.sv
// What this block does
// - Report all three comparator outputs as bits of the interrupt status byte.
// - Session-over status goes 0 to 1 when VBUS drops below session end.
// - Session-end comparator disabled and reads 0 when both edge enables clear.
// - Every session-valid change sends a receive command to the link.
// - Clearing session-valid enables masks interrupts only; receive commands continue.
// - VBUS-valid disabled and status bit 1 reads 0 when both enables clear.
// - External VBUS-valid indicator input is held at constant one.
// - After reset decode is inactive; receive command uses internal comparator.
// - Decode selects internal, fixed 1 or fixed 0 per select, bypass, invert.
// - OTG control bit 3 connects the VBUS pull-down to ground.
// - OTG control bit 4 enables the VBUS pull-up for session request.
// - One session-valid comparator serves both A and B device roles.
// - Select is OTG bit 7, bypass interface bit 6, invert bit 5.
`timescale 1ns/1ps
`default_nettype none

module otg_vbus_monitor_control (
	input wire logic clk,
	input wire logic arst_n,
	input wire vbus_mon_pkg::cmp_t cmp_raw,
	input wire vbus_mon_pkg::edge_en_t edge_en,
	input wire logic [7:0] otg_ctrl,
	input wire logic otg_ctrl_we,
	input wire logic [7:0] ifc_ctrl,
	input wire logic ifc_ctrl_we,
	input wire logic rxcmd_ack,
	output logic [7:0] irq_status,
	output logic rxcmd_req,
	output logic rxcmd_vbus_good,
	output logic rxcmd_session_ok,
	output logic rxcmd_session_over,
	output logic drain_pulldown_ctrl,
	output logic lift_pullup_ctrl,
	output logic ext_indicator_select,
	output logic session_ok_int
);

	////////////////////////////////////////////////////////////////
	// Synchronisers for the analog comparator outputs
	vbus_mon_pkg::cmp_t sync1;
	vbus_mon_pkg::cmp_t sync2;
	vbus_mon_pkg::cmp_t cmp_prev;
	vbus_mon_pkg::cmp_t next_cmp_prev;

	// Comparators are asynchronous to clk, so two stages before any use
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= vbus_mon_pkg::CMP_RESET;
			sync2 <= vbus_mon_pkg::CMP_RESET;
			cmp_prev <= vbus_mon_pkg::CMP_RESET;
		end else begin
			sync1 <= cmp_raw;
			sync2 <= sync1;
			cmp_prev <= next_cmp_prev;
		end
	end

	always_comb begin
		next_cmp_prev = sync2;
	end

	////////////////////////////////////////////////////////////////
	// Control bytes
	logic [7:0] otg_q;
	logic [7:0] ifc_q;
	logic [7:0] next_otg_q;
	logic [7:0] next_ifc_q;

	always_comb begin
		next_otg_q = otg_ctrl_we ? otg_ctrl : otg_q;
		next_ifc_q = ifc_ctrl_we ? ifc_ctrl : ifc_q;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			otg_q <= vbus_mon_pkg::OTG_CTRL_RESET;
			ifc_q <= vbus_mon_pkg::IFC_CTRL_RESET;
		end else begin
			otg_q <= next_otg_q;
			ifc_q <= next_ifc_q;
		end
	end

	assign drain_pulldown_ctrl = otg_q[vbus_mon_pkg::OTG_DRAIN_BIT];
	assign lift_pullup_ctrl = otg_q[vbus_mon_pkg::OTG_LIFT_BIT];
	assign ext_indicator_select = otg_q[vbus_mon_pkg::OTG_EXT_SEL_BIT];
	logic indicator_bypass_qual;
	logic indicator_invert;
	assign indicator_bypass_qual = ifc_q[vbus_mon_pkg::IFC_BYPASS_BIT];
	assign indicator_invert = ifc_q[vbus_mon_pkg::IFC_INVERT_BIT];

	////////////////////////////////////////////////////////////////
	// Comparator gating and status
	logic session_over_flag;
	logic session_ok_flag;
	logic vbus_good_flag;
	logic sess_over_on;
	logic vbus_good_on;

	// session-end enabled if either edge enable is set
	assign sess_over_on = edge_en.rise.session_over | edge_en.fall.session_over;
	assign vbus_good_on = edge_en.rise.vbus_good | edge_en.fall.vbus_good;
	// comparator high once VBUS is below session end
	assign session_over_flag = sync2.session_over & sess_over_on;
	assign session_ok_flag = sync2.session_ok;
	assign vbus_good_flag = sync2.vbus_good & vbus_good_on;

	// status byte carries the three comparator levels
	logic [7:0] next_irq_status;

	always_comb begin
		next_irq_status = 8'h00;
		next_irq_status[vbus_mon_pkg::STAT_VBUS_GOOD_BIT] = vbus_good_flag;
		next_irq_status[vbus_mon_pkg::STAT_SESS_OK_BIT] = session_ok_flag;
		next_irq_status[vbus_mon_pkg::STAT_SESS_OVER_BIT] = session_over_flag;
	end

	// Registered so a read never sees the gating glitch when an enable moves
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status <= 8'h00;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// interrupt pulse only when the matching edge enable is set
	assign session_ok_int = (sync2.session_ok & ~cmp_prev.session_ok & edge_en.rise.session_ok)
		| (~sync2.session_ok & cmp_prev.session_ok & edge_en.fall.session_ok);

	////////////////////////////////////////////////////////////////
	// External indicator decode
	logic ext_indicator;
	logic vbus_src;

	assign ext_indicator = vbus_mon_pkg::EXT_INDICATOR_LEVEL;

	// source select; select resets to 0 so internal is used
	always_comb begin
		if (!ext_indicator_select) begin
			vbus_src = vbus_good_flag;
		end else if (indicator_bypass_qual) begin
			vbus_src = ext_indicator ^ indicator_invert;
		end else begin
			vbus_src = (ext_indicator ^ indicator_invert) & vbus_good_flag;
		end
	end

	////////////////////////////////////////////////////////////////
	// Receive command request
	logic pending;
	logic next_pending;
	logic ok_change;
	logic [2:0] snap;
	logic [2:0] next_snap;

	assign ok_change = sync2.session_ok ^ cmp_prev.session_ok;

	// a change raises the request; a change on the ack cycle wins
	always_comb begin
		next_pending = pending;
		next_snap = snap;
		if (pending && rxcmd_ack) begin
			next_pending = 1'h0;
		end
		if (ok_change) begin
			next_pending = 1'h1;
		end
		if (ok_change || !pending || rxcmd_ack) begin
			next_snap = {session_over_flag, sync2.session_ok, vbus_src};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pending <= 1'h0;
			snap <= 3'h0;
		end else begin
			pending <= next_pending;
			snap <= next_snap;
		end
	end

	assign rxcmd_req = pending;
	assign rxcmd_vbus_good = snap[0];
	assign rxcmd_session_ok = snap[1];
	assign rxcmd_session_over = snap[2];

	////////////////////////////////////////////////////////////////
	// Checks

	a_sess_change_req: assert property (@(posedge clk) disable iff (!arst_n)
		ok_change |=> rxcmd_req && rxcmd_session_ok == $past(sync2.session_ok))
		else $error("session change gave no receive command");

	a_sess_over_gate: assert property (@(posedge clk) disable iff (!arst_n)
		!sess_over_on |=> !irq_status[vbus_mon_pkg::STAT_SESS_OVER_BIT])
		else $error("session end status not gated");

	a_vbus_good_gate: assert property (@(posedge clk) disable iff (!arst_n)
		!vbus_good_on |=> !irq_status[vbus_mon_pkg::STAT_VBUS_GOOD_BIT])
		else $error("vbus valid status not gated");

	// status follows the pin three edges later, once out of reset
	a_status_follow: assert property (@(posedge clk) disable iff (!arst_n)
		$past(arst_n, 3)
		|-> irq_status[vbus_mon_pkg::STAT_SESS_OK_BIT] == $past(cmp_raw.session_ok, 3))
		else $error("status does not follow comparator");

	a_decode_fixed0: assert property (@(posedge clk) disable iff (!arst_n)
		ext_indicator_select && indicator_invert |-> !vbus_src)
		else $error("inverted indicator not fixed 0");

	a_decode_internal: assert property (@(posedge clk) disable iff (!arst_n)
		!ext_indicator_select |-> vbus_src == vbus_good_flag)
		else $error("internal source not used");

	a_drain_write: assert property (@(posedge clk) disable iff (!arst_n)
		otg_ctrl_we |=> drain_pulldown_ctrl == $past(otg_ctrl[vbus_mon_pkg::OTG_DRAIN_BIT]))
		else $error("pull-down not set by bit 3");

	a_lift_write: assert property (@(posedge clk) disable iff (!arst_n)
		otg_ctrl_we |=> lift_pullup_ctrl == $past(otg_ctrl[vbus_mon_pkg::OTG_LIFT_BIT]))
		else $error("pull-up not set by bit 4");

	sequence s_masked_change;
		ok_change && !edge_en.rise.session_ok && !edge_en.fall.session_ok;
	endsequence

	sequence s_quiet_then_cmd;
		!session_ok_int ##1 rxcmd_req;
	endsequence

	a_sess_no_int: assert property (@(posedge clk) disable iff (!arst_n)
		s_masked_change |-> s_quiet_then_cmd)
		else $error("masked session change lost its command");

endmodule

`default_nettype wire

// >>> vbus_mon_pkg.sv
package vbus_mon_pkg;
	// Bit positions in the interrupt status byte
	localparam int unsigned STAT_VBUS_GOOD_BIT = 1;
	localparam int unsigned STAT_SESS_OK_BIT = 2;
	localparam int unsigned STAT_SESS_OVER_BIT = 3;
	// Bit positions in the OTG control and interface control bytes
	localparam int unsigned OTG_DRAIN_BIT = 3;
	localparam int unsigned OTG_LIFT_BIT = 4;
	localparam int unsigned OTG_EXT_SEL_BIT = 7;
	localparam int unsigned IFC_INVERT_BIT = 5;
	localparam int unsigned IFC_BYPASS_BIT = 6;
	// Reset values
	localparam logic [2:0] CMP_RESET = 3'h0;
	localparam logic [7:0] OTG_CTRL_RESET = 8'h00;
	localparam logic [7:0] IFC_CTRL_RESET = 8'h00;
	// The external indicator input is strapped high inside the device
	localparam logic EXT_INDICATOR_LEVEL = 1'h1;

	// Comparator triple
	typedef struct packed {
		logic session_over;
		logic session_ok;
		logic vbus_good;
	} cmp_t;

	// Edge interrupt enables for the three comparators
	typedef struct packed {
		cmp_t rise;
		cmp_t fall;
	} edge_en_t;
endpackage

// >>> link_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic rxcmd_req,
	input wire logic rxcmd_session_ok,
	input wire logic [3:0] ack_delay,
	output logic rxcmd_ack,
	output logic running
);
	logic [3:0] cnt;
	// One ack per command; the cycle after an ack never acks, so a command
	// raised again in the ack cycle is still taken once the old one drains
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 4'h0;
			rxcmd_ack <= 1'b0;
			running <= 1'b0;
		end else if (!rxcmd_req || rxcmd_ack) begin
			cnt <= 4'h0;
			rxcmd_ack <= 1'b0;
		end else if (cnt >= ack_delay) begin
			rxcmd_ack <= 1'b1;
			running <= rxcmd_session_ok;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> otg_vbus_monitor_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module otg_vbus_monitor_control_bench;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	vbus_mon_pkg::cmp_t cmp_raw = 3'h0;
	vbus_mon_pkg::edge_en_t edge_en = 6'h3f;
	logic [7:0] otg_ctrl = 8'h00;
	logic [7:0] ifc_ctrl = 8'h00;
	logic otg_ctrl_we = 1'b0;
	logic ifc_ctrl_we = 1'b0;
	logic [3:0] ack_delay = 4'h0;
	logic rxcmd_ack, rxcmd_req, rxcmd_vbus_good, rxcmd_session_ok, rxcmd_session_over;
	logic drain_pulldown_ctrl, lift_pullup_ctrl, ext_indicator_select, session_ok_int;
	logic [7:0] irq_status;
	logic running;
	int n_fail = 0;
	int samples_checked = 0;
	always #25 clk = ~clk;
	otg_vbus_monitor_control u_otg_vbus_monitor_control (.clk(clk), .arst_n(arst_n),
		.cmp_raw(cmp_raw), .edge_en(edge_en), .otg_ctrl(otg_ctrl), .otg_ctrl_we(otg_ctrl_we),
		.ifc_ctrl(ifc_ctrl), .ifc_ctrl_we(ifc_ctrl_we), .rxcmd_ack(rxcmd_ack),
		.irq_status(irq_status), .rxcmd_req(rxcmd_req), .rxcmd_vbus_good(rxcmd_vbus_good),
		.rxcmd_session_ok(rxcmd_session_ok), .rxcmd_session_over(rxcmd_session_over),
		.drain_pulldown_ctrl(drain_pulldown_ctrl), .lift_pullup_ctrl(lift_pullup_ctrl),
		.ext_indicator_select(ext_indicator_select), .session_ok_int(session_ok_int));
	link_model u_link_model (.clk(clk), .arst_n(arst_n), .rxcmd_req(rxcmd_req),
		.rxcmd_session_ok(rxcmd_session_ok), .ack_delay(ack_delay), .rxcmd_ack(rxcmd_ack),
		.running(running));
	////////////////////////////////////////////////////////////////////////
	// Compare helpers
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	// Control writes are one-cycle enable pulses
	task automatic wr(input logic [7:0] o, input logic [7:0] i);
		@(posedge clk);
		otg_ctrl <= o;
		ifc_ctrl <= i;
		otg_ctrl_we <= 1'b1;
		ifc_ctrl_we <= 1'b1;
		@(posedge clk);
		otg_ctrl_we <= 1'b0;
		ifc_ctrl_we <= 1'b0;
		#1;
	endtask
	// Toggle session valid, judge the command and interrupt, wait for the ack
	task automatic sess_cmd(input logic exp_vbus, input logic exp_int, input logic exp_over);
		logic now_ok;
		int pulses;
		int i;
		now_ok = ~cmp_raw.session_ok;
		pulses = 0;
		@(posedge clk);
		cmp_raw.session_ok <= now_ok;
		for (i = 0; i < 20 && rxcmd_req !== 1'b1; i++) begin
			@(posedge clk);
			#1;
			pulses += int'(session_ok_int === 1'b1);
		end
		if (i == 20) begin
			n_fail++;
			end_sim();
		end
		check("rxcmd_session_ok", 8'(rxcmd_session_ok), 8'(now_ok));
		check("rxcmd_vbus_good", 8'(rxcmd_vbus_good), 8'(exp_vbus));
		check("rxcmd_session_over", 8'(rxcmd_session_over), 8'(exp_over));
		check("session_ok_int", pulses[7:0], 8'(exp_int));
		check("irq_ok_bit", 8'(irq_status[vbus_mon_pkg::STAT_SESS_OK_BIT]), 8'(now_ok));
		for (i = 0; i < 30 && rxcmd_req !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 30) begin
			n_fail++;
			end_sim();
		end
		check("link_running", 8'(running), 8'(now_ok));
	endtask
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		check("pulls", 8'({drain_pulldown_ctrl, lift_pullup_ctrl}), 8'h00);
		check("ext_indicator_select", 8'(ext_indicator_select), 8'h00);
		check("irq_status", irq_status, 8'h00);
	endtask
	task automatic t_status();
		@(posedge clk);
		cmp_raw <= 3'h5;
		settle();
		check("irq_status", irq_status, 8'h0a);
		@(posedge clk);
		edge_en <= 6'h12;
		settle();
		check("irq_status", irq_status, 8'h00);
		check("irq_good_bit", 8'(irq_status[vbus_mon_pkg::STAT_VBUS_GOOD_BIT]), 8'h00);
		@(posedge clk);
		cmp_raw.vbus_good <= 1'b0;
		edge_en <= 6'h00;
		settle();
		sess_cmd(1'b0, 1'b0, 1'b0);
		@(posedge clk);
		edge_en <= 6'h3f;
		settle();
	endtask
	task automatic t_pull();
		wr(8'h08, 8'h00);
		check("drain_lift", 8'({drain_pulldown_ctrl, lift_pullup_ctrl}), 8'h02);
		wr(8'h10, 8'h00);
		check("drain_lift", 8'({drain_pulldown_ctrl, lift_pullup_ctrl}), 8'h01);
		wr(8'h80, 8'h00);
		check("ext_indicator_select", 8'(ext_indicator_select), 8'h01);
		wr(8'h00, 8'h00);
	endtask
	// Every select, bypass, invert case with both comparator levels; acks slow down
	task automatic t_decode();
		logic ev;
		for (int k = 0; k < 16; k++) begin
			ev = !k[3] ? k[0] : (k[2] ? !k[1] : (!k[1] && k[0]));
			@(posedge clk);
			ack_delay <= 4'(k);
			cmp_raw.vbus_good <= k[0];
			wr({k[3], 7'h0}, {1'b0, k[2], k[1], 5'h0});
			settle();
			sess_cmd(ev, 1'b1, 1'b1);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_status();
		t_pull();
		t_decode();
		end_sim();
	end
endmodule
`default_nettype wire
